// [src/alcu_pkg.sv]
// Package with constants, types and operation codes of the accumulator logic and compare unit.
//
// Overview of operation
// - A 16-bit AND combines the low accumulator half with the memory word and writes the result back.
// - A 32-bit AND combines the whole accumulator with two memory words or an immediate.
// - A 16-bit OR combines the low accumulator half with the memory word and writes the result back.
// - A 32-bit OR combines the whole accumulator with two memory words or an immediate.
// - A 16-bit XOR combines the low accumulator half with the memory word and writes the result back.
// - A 32-bit XOR combines the whole accumulator with two memory words or an immediate.
// - An immediate for the 32-bit logic forms must lie in 0 to 0FFFFFFF, otherwise the operation is refused.
// - Every logic operation sets the zero flag exactly when the accumulator result is zero.
// - Every logic operation sets the negative flag when bit 31 of the accumulator result is set.
// - A 16-bit compare checks the low accumulator half against the memory word and only touches the compare flags.
// - The less flag is set when the accumulator value is below the operand.
// - The equal flag is set when the accumulator value equals the operand.
// - The greater flag is set when the accumulator value is above the operand.
// - A flag holds until the next operation that drives that same flag, so users must sample it before then.
package alcu_pkg;

	localparam int          DATA_W        = 32;
	localparam int          HALF_W        = 16;
	localparam int          ADDR_W        = 12;
	localparam int          IRQ_W         = 4;

	localparam logic [31:0] IMM_MAX       = 32'h0FFFFFFF;

	localparam logic [11:0] CTRL_OFS      = 12'h000;
	localparam logic [11:0] ACC_OFS       = 12'h004;
	localparam logic [11:0] FLAGS_OFS     = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFS  = 12'h00C;
	localparam logic [11:0] IRQ_MASK_OFS  = 12'h010;
	localparam logic [11:0] OP_COUNT_OFS  = 12'h014;

	localparam int          CTRL_EN_BIT   = 0;
	localparam logic        CTRL_EN_RST   = 1'b1;
	localparam logic [31:0] ACC_RST       = 32'h00000000;
	localparam logic [3:0]  IRQ_MASK_RST  = 4'h0;

	localparam int          IRQ_LOGIC_BIT = 0;
	localparam int          IRQ_COMPARE_BIT = 1;
	localparam int          IRQ_RANGE_BIT = 2;
	localparam int          IRQ_IGN_BIT   = 3;

	localparam int          FLAG_ZERO_BIT = 0;
	localparam int          FLAG_NEG_BIT  = 1;
	localparam int          FLAG_LESS_BIT = 2;
	localparam int          FLAG_EQ_BIT   = 3;
	localparam int          FLAG_GT_BIT   = 4;

	// Operation codes presented by the sequencer.
	typedef enum logic [2:0]
	{
		no_op           = 3'h0,
		and_word_op     = 3'h1,
		and_double_op   = 3'h2,
		or_word_op      = 3'h3,
		or_double_op    = 3'h4,
		xor_word_op     = 3'h5,
		xor_double_op   = 3'h6,
		compare_word_op = 3'h7
	} alcu_op_e;

	// One request from the sequencer with the operand fetched from data memory.
	typedef struct packed
	{
		alcu_op_e          code;
		logic              use_imm;
		logic [HALF_W-1:0] mem_hi;
		logic [HALF_W-1:0] mem_lo;
		logic [DATA_W-1:0] imm;
	} alcu_op_s;

	typedef struct packed
	{
		logic greater_flag;
		logic equal_flag;
		logic less_flag;
		logic negative_flag;
		logic zero_flag;
	} alcu_flags_s;

endpackage

// [src/alcu_logic_core.sv]
// Combinational logic and compare datapath of the accumulator unit.
`timescale 1ns/1ps
module alcu_logic_core #(
	parameter int DATA_W = alcu_pkg::DATA_W,
	parameter int HALF_W = alcu_pkg::HALF_W
) (
	input  wire alcu_pkg::alcu_op_e code,
	input  wire logic [DATA_W-1:0]  acc,
	input  wire logic [DATA_W-1:0]  operand,
	output logic [DATA_W-1:0]       result,
	output logic                    writes_acc,
	output logic                    is_compare,
	output logic                    less,
	output logic                    equal,
	output logic                    greater
);

	logic [HALF_W-1:0] acc_lo;
	logic [HALF_W-1:0] opd_lo;

	assign acc_lo = acc[HALF_W-1:0];
	assign opd_lo = operand[HALF_W-1:0];

	always_comb
	begin
		result     = acc;
		writes_acc = 1'b1;
		is_compare = 1'b0;
		case (code)
			alcu_pkg::and_word_op:     result[HALF_W-1:0] = acc_lo & opd_lo;
			alcu_pkg::and_double_op:   result = acc & operand;
			alcu_pkg::or_word_op:      result[HALF_W-1:0] = acc_lo | opd_lo;
			alcu_pkg::or_double_op:    result = acc | operand;
			alcu_pkg::xor_word_op:     result[HALF_W-1:0] = acc_lo ^ opd_lo;
			alcu_pkg::xor_double_op:   result = acc ^ operand;
			alcu_pkg::compare_word_op:
			begin
				writes_acc = 1'b0;
				is_compare = 1'b1;
			end
			default:                   writes_acc = 1'b0;
		endcase
	end

	// Unsigned compare of the low accumulator half.
	assign less    = acc_lo < opd_lo;
	assign equal   = acc_lo == opd_lo;
	assign greater = acc_lo > opd_lo;

endmodule

// [src/alcu_unit.sv]
// Accumulator logic and compare unit with sequencer port and APB register slave.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module alcu_unit #(
	parameter int DATA_W = alcu_pkg::DATA_W,
	parameter int HALF_W = alcu_pkg::HALF_W,
	parameter int ADDR_W = alcu_pkg::ADDR_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic [31:0]              prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                op_valid,
	input  wire alcu_pkg::alcu_op_s  op_req,
	output logic                     op_ready,
	output logic                     op_done,
	output logic [DATA_W-1:0]        acc_value,
	output alcu_pkg::alcu_flags_s    flags,
	output logic                     irq
);

	localparam int IRQ_W = alcu_pkg::IRQ_W;

	logic                  ctrl_enable;
	logic [IRQ_W-1:0]      irq_status;
	logic [IRQ_W-1:0]      irq_mask;
	logic [IRQ_W-1:0]      irq_event;
	logic [IRQ_W-1:0]      read_clear;
	logic [31:0]           op_count;

	logic                  is_double;
	logic                  range_bad;
	logic                  op_seen;
	logic                  op_exec;
	logic                  op_ignored;
	logic [DATA_W-1:0]     operand;
	logic [DATA_W-1:0]     core_result;
	logic                  core_writes;
	logic                  core_compare;
	logic                  core_less;
	logic                  core_equal;
	logic                  core_greater;

	logic                  apb_setup;
	logic                  apb_access;
	logic                  apb_write;
	logic                  addr_hit;
	logic [31:0]           next_prdata;
	logic                  clear_pending;
	logic [IRQ_W-1:0]      clear_bits;

	// The unit finishes every operation in the cycle it is presented, so it never stalls the sequencer.
	assign op_ready = 1'b1;

	assign is_double = (op_req.code == alcu_pkg::and_double_op)
		|| (op_req.code == alcu_pkg::or_double_op)
		|| (op_req.code == alcu_pkg::xor_double_op);

	// An immediate beyond the allowed constant range is refused.
	assign range_bad = is_double && op_req.use_imm && (op_req.imm > alcu_pkg::IMM_MAX);

	assign op_seen    = op_valid && (op_req.code != alcu_pkg::no_op);
	assign op_exec    = op_seen && ctrl_enable && !range_bad;
	assign op_ignored = op_seen && !ctrl_enable;

	// Word forms use the first memory word; double forms pair low then high word, or take the immediate.
	always_comb
	begin
		if (!is_double)
		begin
			operand = {{(DATA_W-HALF_W){1'b0}}, op_req.mem_lo};
		end
		else if (op_req.use_imm)
		begin
			operand = op_req.imm;
		end
		else
		begin
			operand = {op_req.mem_hi, op_req.mem_lo};
		end
	end

	alcu_logic_core #(
		.DATA_W (DATA_W),
		.HALF_W (HALF_W)
	) u_core (
		.code       (op_req.code),
		.acc        (acc_value),
		.operand    (operand),
		.result     (core_result),
		.writes_acc (core_writes),
		.is_compare (core_compare),
		.less       (core_less),
		.equal      (core_equal),
		.greater    (core_greater)
	);

	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable;
	assign apb_write  = apb_access && pwrite;
	assign pready     = 1'b1;

	always_comb
	begin
		addr_hit = 1'b1;
		case (paddr)
			alcu_pkg::CTRL_OFS,
			alcu_pkg::ACC_OFS,
			alcu_pkg::FLAGS_OFS,
			alcu_pkg::IRQ_STAT_OFS,
			alcu_pkg::IRQ_MASK_OFS,
			alcu_pkg::OP_COUNT_OFS: addr_hit = 1'b1;
			default:                addr_hit = 1'b0;
		endcase
	end

	// Read data are gathered in the setup phase so that they come from a flip-flop in the access phase.
	always_comb
	begin
		next_prdata = 32'h00000000;
		case (paddr)
			alcu_pkg::CTRL_OFS:     next_prdata[alcu_pkg::CTRL_EN_BIT] = ctrl_enable;
			alcu_pkg::ACC_OFS:      next_prdata = acc_value;
			alcu_pkg::FLAGS_OFS:    next_prdata[4:0] = flags;
			alcu_pkg::IRQ_STAT_OFS: next_prdata[IRQ_W-1:0] = irq_status;
			alcu_pkg::IRQ_MASK_OFS: next_prdata[IRQ_W-1:0] = irq_mask;
			alcu_pkg::OP_COUNT_OFS: next_prdata = op_count;
			default:                next_prdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			prdata  <= pwrite ? 32'h00000000 : next_prdata;
			pslverr <= !addr_hit;
		end
	end

	// Only the status bits that were actually returned by the read are cleared at its access edge.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clear_pending <= 1'b0;
			clear_bits    <= 4'h0;
		end
		else
		begin
			clear_pending <= apb_setup && !pwrite && (paddr == alcu_pkg::IRQ_STAT_OFS);
			clear_bits    <= irq_status;
		end
	end

	assign read_clear = (clear_pending && apb_access && !pwrite) ? clear_bits : 4'h0;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_enable <= alcu_pkg::CTRL_EN_RST;
		end
		else if (apb_write && (paddr == alcu_pkg::CTRL_OFS))
		begin
			ctrl_enable <= pwdata[alcu_pkg::CTRL_EN_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_mask <= alcu_pkg::IRQ_MASK_RST;
		end
		else if (apb_write && (paddr == alcu_pkg::IRQ_MASK_OFS))
		begin
			irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	// The sequencer's result has priority over a software write to the accumulator in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_value <= alcu_pkg::ACC_RST;
		end
		else if (op_exec && core_writes)
		begin
			acc_value <= core_result;
		end
		else if (apb_write && (paddr == alcu_pkg::ACC_OFS))
		begin
			acc_value <= pwdata[DATA_W-1:0];
		end
	end

	// Logic forms drive zero and negative; the compare drives only its three flags.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags.zero_flag     <= 1'b0;
			flags.negative_flag <= 1'b0;
		end
		else if (op_exec && core_writes)
		begin
			flags.zero_flag     <= (core_result == '0);
			flags.negative_flag <= core_result[DATA_W-1];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flags.less_flag    <= 1'b0;
			flags.equal_flag   <= 1'b0;
			flags.greater_flag <= 1'b0;
		end
		else if (op_exec && core_compare)
		begin
			flags.less_flag    <= core_less;
			flags.equal_flag   <= core_equal;
			flags.greater_flag <= core_greater;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_done <= 1'b0;
		end
		else
		begin
			op_done <= op_exec;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			op_count <= 32'h00000000;
		end
		else if (op_exec)
		begin
			op_count <= op_count + 32'h00000001;
		end
	end

	always_comb
	begin
		irq_event                          = 4'h0;
		irq_event[alcu_pkg::IRQ_LOGIC_BIT] = op_exec && core_writes;
		irq_event[alcu_pkg::IRQ_COMPARE_BIT] = op_exec && core_compare;
		irq_event[alcu_pkg::IRQ_RANGE_BIT] = op_seen && ctrl_enable && range_bad;
		irq_event[alcu_pkg::IRQ_IGN_BIT]   = op_ignored;
	end

	// A new event in the clearing cycle survives because the set term is applied after the clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_status <= 4'h0;
		end
		else
		begin
			irq_status <= (irq_status & ~read_clear) | irq_event;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq <= 1'b0;
		end
		else
		begin
			irq <= |(((irq_status & ~read_clear) | irq_event) & irq_mask);
		end
	end

endmodule

// [bench/alcu_unit_checker.sv]
// Concurrent checks on the ports of the accumulator logic and compare unit.
`timescale 1ns/1ps
module alcu_unit_checker #(
	parameter int DATA_W = alcu_pkg::DATA_W
) (
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  op_valid,
	input wire alcu_pkg::alcu_op_s    op_req,
	input wire logic                  op_done,
	input wire logic [DATA_W-1:0]     acc_value,
	input wire alcu_pkg::alcu_flags_s flags
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wire is_compare = op_req.code == alcu_pkg::compare_word_op;
	wire dbl = op_req.code inside {alcu_pkg::and_double_op, alcu_pkg::or_double_op, alcu_pkg::xor_double_op};
	wire imm_bad = op_valid && dbl && op_req.use_imm && op_req.imm > alcu_pkg::IMM_MAX;

	function automatic logic [31:0] calc(alcu_pkg::alcu_op_s r, logic [31:0] a);
		logic [31:0] v;
		v = r.use_imm ? r.imm : {r.mem_hi, r.mem_lo};
		case (r.code)
			alcu_pkg::and_word_op: calc = {a[31:16], a[15:0] & r.mem_lo};
			alcu_pkg::or_word_op: calc = {a[31:16], a[15:0] | r.mem_lo};
			alcu_pkg::xor_word_op: calc = {a[31:16], a[15:0] ^ r.mem_lo};
			alcu_pkg::and_double_op: calc = a & v;
			alcu_pkg::or_double_op: calc = a | v;
			alcu_pkg::xor_double_op: calc = a ^ v;
			default: calc = a;
		endcase
	endfunction

	done_cause_a:
		assert property (op_done |-> $past(op_valid) && $past(op_req.code) != alcu_pkg::no_op)
		else $error("op done without a request");
	logic_result_a:
		assert property (op_done && !$past(is_compare) |-> acc_value == calc($past(op_req), $past(acc_value)))
		else $error("logic result wrong");
	imm_refuse_a:
		assert property (imm_bad |=> !op_done)
		else $error("oversized immediate executed");
	zero_flag_a:
		assert property (op_done && !$past(is_compare) |-> flags.zero_flag == (acc_value == '0))
		else $error("zero flag wrong");
	neg_flag_a:
		assert property (op_done && !$past(is_compare) |-> flags.negative_flag == acc_value[31])
		else $error("negative flag wrong");
	compare_keeps_a:
		assert property (op_done && $past(is_compare) |-> $stable(acc_value) && $stable(flags.zero_flag))
		else $error("compare touched accumulator");
	compare_flags_a:
		assert property (op_done && $past(is_compare) |-> {flags.less_flag, flags.equal_flag, flags.greater_flag} ==
			{$past(acc_value[15:0]) < $past(op_req.mem_lo), $past(acc_value[15:0]) == $past(op_req.mem_lo),
			$past(acc_value[15:0]) > $past(op_req.mem_lo)})
		else $error("compare flags wrong");
	flags_hold_a:
		assert property (!op_done |-> $stable(flags))
		else $error("flags changed without an op");

	cover property (op_done && $past(is_compare));
	cover property (op_done && $past(dbl) && $past(op_req.use_imm));
	cover property (imm_bad);
endmodule

bind alcu_unit alcu_unit_checker #(.DATA_W(DATA_W)) u_checker (.pclk(pclk), .presetn(presetn),
	.op_valid(op_valid), .op_req(op_req), .op_done(op_done), .acc_value(acc_value), .flags(flags));

// [bench/alcu_seq_model.sv]
// Behavioural model of the instruction sequencer and its data memory.
`timescale 1ns/1ps
module alcu_seq_model (
	input  wire logic          pclk,
	output logic               op_valid,
	output alcu_pkg::alcu_op_s op_req
);
	logic [15:0] mem [0:15];

	initial
	begin
		op_valid = 1'b0;
		op_req = '0;
	end

	// Presents one request for a single cycle after a gap, then scrambles the released lines.
	task automatic issue(input int gap, input alcu_pkg::alcu_op_e code, input logic [3:0] addr,
		input logic imm_sel, input logic [31:0] imm);
		repeat (gap) @(posedge pclk);
		@(posedge pclk);
		op_valid <= 1'b1;
		op_req <= '{code, imm_sel, mem[addr + 4'h1], mem[addr], imm};
		@(posedge pclk);
		op_valid <= 1'b0;
		op_req <= alcu_pkg::alcu_op_s'(~op_req);
	endtask
endmodule

// [bench/alcu_unit_bench.sv]
// Self-checking testbench of the accumulator logic and compare unit.
`timescale 1ns/1ps
`define CHK(g, x) \
	begin \
		n_compared++; \
		if ((g) !== (x)) \
		begin \
			n_errors++; \
			$display("CHECK FAILED at %0t: got %h expected %h", $time, (g), (x)); \
		end \
	end
module alcu_unit_bench;
	logic                  pclk = 1'b0;
	logic                  presetn = 1'b0;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h00000000;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  op_valid;
	logic                  op_ready;
	alcu_pkg::alcu_op_s    op_req;
	logic                  op_done;
	logic [31:0]           acc_value;
	alcu_pkg::alcu_flags_s flags;
	logic                  irq;
	logic [31:0]           m_acc = 32'h00000000;
	alcu_pkg::alcu_flags_s m_fl = '0;
	logic [3:0]            m_st = 4'h0;
	logic [3:0]            m_mask = 4'h0;
	logic                  m_en = 1'b1;
	logic [31:0]           m_cnt = 32'h00000000;
	logic [31:0]           r;
	int                    n_errors = 0;
	int                    n_compared = 0;

	always #5 pclk = ~pclk;

	alcu_unit DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.op_valid(op_valid), .op_req(op_req), .op_ready(op_ready), .op_done(op_done), .acc_value(acc_value),
		.flags(flags), .irq(irq));
	alcu_seq_model seq (.pclk(pclk), .op_valid(op_valid), .op_req(op_req));

	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
			n++;
		end
		`CHK(n, 0)
		if (!w)
			`CHK(prdata, x)
		`CHK(pslverr, a > 12'h014)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic run(input alcu_pkg::alcu_op_e c, input logic [3:0] a, input logic s, input logic [31:0] k);
		logic [15:0] lo;
		logic [31:0] v;
		logic        ok;
		lo = seq.mem[a];
		v = s ? k : {seq.mem[a + 4'h1], lo};
		ok = m_en && !(c inside {alcu_pkg::and_double_op, alcu_pkg::or_double_op, alcu_pkg::xor_double_op}
			&& s && k > alcu_pkg::IMM_MAX);
		if (c == alcu_pkg::no_op)
			ok = 1'b0;
		else if (!m_en)
			m_st[3] = 1'b1;
		else if (!ok)
			m_st[2] = 1'b1;
		else if (c == alcu_pkg::compare_word_op)
		begin
			m_fl.less_flag = m_acc[15:0] < lo;
			m_fl.equal_flag = m_acc[15:0] == lo;
			m_fl.greater_flag = m_acc[15:0] > lo;
			m_st[1] = 1'b1;
		end
		else
		begin
			case (c)
				alcu_pkg::and_word_op: m_acc[15:0] &= lo;
				alcu_pkg::or_word_op: m_acc[15:0] |= lo;
				alcu_pkg::xor_word_op: m_acc[15:0] ^= lo;
				alcu_pkg::and_double_op: m_acc &= v;
				alcu_pkg::or_double_op: m_acc |= v;
				default: m_acc ^= v;
			endcase
			m_fl.zero_flag = m_acc == 32'h00000000;
			m_fl.negative_flag = m_acc[31];
			m_st[0] = 1'b1;
		end
		if (ok)
			m_cnt = m_cnt + 32'h00000001;
		seq.issue($urandom_range(2, 0), c, a, s, k);
		@(negedge pclk);
		`CHK(op_ready, 1'b1)
		`CHK(op_done, ok)
		`CHK(acc_value, m_acc)
		`CHK(flags, m_fl)
		@(negedge pclk);
		`CHK(irq, |(m_st & m_mask))
	endtask

	initial
	begin
		#100000;
		n_errors++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(32'h939553BE));
		for (int i = 0; i < 16; i++)
			seq.mem[i] = 16'($urandom);
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, alcu_pkg::CTRL_OFS, 32'h0, 32'h00000001);
		apb(1'b0, alcu_pkg::ACC_OFS, 32'h0, 32'h00000000);
		apb(1'b0, alcu_pkg::FLAGS_OFS, 32'h0, 32'h00000000);
		apb(1'b0, alcu_pkg::IRQ_MASK_OFS, 32'h0, 32'h00000000);
		apb(1'b0, alcu_pkg::IRQ_STAT_OFS, 32'h0, 32'h00000000);
		apb(1'b0, alcu_pkg::OP_COUNT_OFS, 32'h0, 32'h00000000);
		apb(1'b0, 12'h018, 32'h0, 32'h00000000);
		apb(1'b1, 12'h018, 32'hFFFFFFFF, 32'h0);
		$display("test reset values done");
		apb(1'b1, alcu_pkg::ACC_OFS, 32'hF0F0A5A5, 32'h0);
		m_acc = 32'hF0F0A5A5;
		apb(1'b1, alcu_pkg::IRQ_MASK_OFS, 32'h00000005, 32'h0);
		m_mask = 4'h5;
		for (int c = 1; c < 8; c++)
			run(alcu_pkg::alcu_op_e'(3'(c)), 4'(c), 1'b0, 32'h0);
		run(alcu_pkg::or_double_op, 4'h0, 1'b1, alcu_pkg::IMM_MAX);
		run(alcu_pkg::and_double_op, 4'h0, 1'b1, alcu_pkg::IMM_MAX + 32'h1);
		run(alcu_pkg::and_double_op, 4'h0, 1'b1, 32'h00000000);
		run(alcu_pkg::compare_word_op, 4'h3, 1'b0, 32'h0);
		run(alcu_pkg::no_op, 4'h2, 1'b0, 32'h0);
		apb(1'b1, alcu_pkg::FLAGS_OFS, 32'hFFFFFFFF, 32'h0);
		apb(1'b0, alcu_pkg::FLAGS_OFS, 32'h0, 32'(m_fl));
		$display("test directed ops done");
		for (int i = 0; i < 60; i++)
		begin
			run(alcu_pkg::alcu_op_e'(3'($urandom_range(7, 1))), 4'($urandom), 1'($urandom), $urandom & 32'h1FFFFFFF);
			if (i % 15 == 14)
			begin
				apb(1'b0, alcu_pkg::IRQ_STAT_OFS, 32'h0, 32'(m_st));
				m_st = 4'h0;
				r = $urandom;
				apb(1'b1, alcu_pkg::IRQ_MASK_OFS, r, 32'h0);
				m_mask = r[3:0];
			end
		end
		$display("test random ops done");
		apb(1'b1, alcu_pkg::IRQ_MASK_OFS, 32'h0000000F, 32'h0);
		m_mask = 4'hF;
		apb(1'b1, alcu_pkg::CTRL_OFS, 32'h0, 32'h0);
		m_en = 1'b0;
		run(alcu_pkg::xor_word_op, 4'h5, 1'b0, 32'h0);
		apb(1'b1, alcu_pkg::CTRL_OFS, 32'h1, 32'h0);
		m_en = 1'b1;
		apb(1'b0, alcu_pkg::IRQ_STAT_OFS, 32'h0, 32'(m_st));
		m_st = 4'h0;
		apb(1'b0, alcu_pkg::IRQ_STAT_OFS, 32'h0, 32'h00000000);
		apb(1'b0, alcu_pkg::OP_COUNT_OFS, 32'h0, m_cnt);
		@(negedge pclk);
		`CHK(irq, 1'b0)
		$display("test interrupts and disable done");
		end_of_test();
	end
endmodule
